// ===== pio_pkg.sv
package pio_pkg;
   // Register byte addresses
   localparam logic [3:0] PORT_A_DATA_OFS = 4'h0;
   localparam logic [3:0] PORT_A_CONTROL_OFS = 4'h4;
   localparam logic [3:0] PORT_B_DATA_OFS = 4'h8;
   localparam logic [3:0] PORT_B_CONTROL_OFS = 4'hc;
   // Control byte layout: bits 7:6 mode, low nibble all ones selects mode; else direction
   localparam int MODE_POS = 6;
   localparam logic [1:0] MODE_BIT_IO = 2'h3;
   localparam logic [3:0] MODE_WORD_LOW = 4'hf;
   localparam logic [7:0] DIR_RESET = 8'hff;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [1:0] MODE_RESET = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int BUS_DRIVER_ENABLE_BIT = 0;
   localparam int TIMEKEEPER_RESET_N_BIT = 1;
   localparam int TIMEKEEPER_SERIAL_DATA_BIT = 2;
   localparam int TIMEKEEPER_SERIAL_CLOCK_BIT = 3;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [1:0] mode;
   } port_cfg_t;
endpackage

// ===== parallel_bit_io_ports.sv
`timescale 1ns/1ps
// Function
// - Port A offers all eight lines in modes 0, 1 and 3.
// - Port B runs in bit mode 3 only; all mode words are ignored.
// - Port B lines 4 to 7 stay general purpose.
// - B line 0 is bus driver enable, line 1 timekeeper reset low.
// - Each port has one data and one control register, four total.
// - Port A control write in mode 3: 1 makes input, 0 makes output.
// - Port B control write: 1 makes input, 0 makes output.
// - Port A data read returns the driven output latch.
// - Port B data read returns the output latch for read-modify-write.
module parallel_bit_io_ports (
   input wire logic sys_clk_i, // 200 MHz clock
   input wire logic reset_n_i, // Async reset, active low
   input wire logic [31:0] s_axi_awaddr_i, // Write address
   input wire logic s_axi_awvalid_i, // Write address valid
   output logic s_axi_awready_o, // Write address ready
   input wire logic [31:0] s_axi_wdata_i, // Write data
   input wire logic [3:0] s_axi_wstrb_i, // Write strobes
   input wire logic s_axi_wvalid_i, // Write data valid
   output logic s_axi_wready_o, // Write data ready
   output logic [1:0] s_axi_bresp_o, // Write response
   output logic s_axi_bvalid_o, // Write response valid
   input wire logic s_axi_bready_i, // Write response ready
   input wire logic [31:0] s_axi_araddr_i, // Read address
   input wire logic s_axi_arvalid_i, // Read address valid
   output logic s_axi_arready_o, // Read address ready
   output logic [31:0] s_axi_rdata_o, // Read data
   output logic [1:0] s_axi_rresp_o, // Read response
   output logic s_axi_rvalid_o, // Read data valid
   input wire logic s_axi_rready_i, // Read data ready
   input wire logic [7:0] port_a_in_i, // Port A pin levels
   output logic [7:0] port_a_out_o, // Port A drive value
   output logic [7:0] port_a_oe_n_o, // Port A enable, low drives
   output logic [1:0] port_a_mode_o, // Port A mode
   input wire logic [7:0] port_b_in_i, // Port B pin levels
   output logic [7:0] port_b_out_o, // Port B drive value
   output logic [7:0] port_b_oe_n_o // Port B enable, low drives
);
   pio_pkg::port_cfg_t port_a_ff;
   pio_pkg::port_cfg_t port_b_ff;
   logic [7:0] a_sync1_ff, a_sync2_ff, b_sync1_ff, b_sync2_ff;
   logic aw_held_ff, w_held_ff;
   logic [3:0] awaddr_ff;
   logic [7:0] wbyte_ff;
   logic wstrb0_ff;
   logic aw_bad_ff;
   logic do_write;
   logic [3:0] rd_addr;
   logic [31:0] nxt_rdata;
   logic nxt_rerr;

   // Pin inputs are asynchronous to the bus clock
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         a_sync1_ff <= 8'h00;
         a_sync2_ff <= 8'h00;
         b_sync1_ff <= 8'h00;
         b_sync2_ff <= 8'h00;
      end else begin
         a_sync1_ff <= port_a_in_i;
         a_sync2_ff <= a_sync1_ff;
         b_sync1_ff <= port_b_in_i;
         b_sync2_ff <= b_sync1_ff;
      end
   end

   // Address and data may arrive in either order; each is held until both are in
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wbyte_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         aw_bad_ff <= 1'b0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr_i[3:0];
            // Upper bits must be zero, else an address past the map aliases one of the four port registers
            aw_bad_ff <= (s_axi_awaddr_i[31:4] != 28'h0000000) || (s_axi_awaddr_i[1:0] != 2'h0);
         end else if (do_write) begin
            aw_held_ff <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_ff <= 1'b1;
            wbyte_ff <= s_axi_wdata_i[7:0];
            wstrb0_ff <= s_axi_wstrb_i[0];
         end else if (do_write) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   // Refused writes still get a response, so the master never hangs
   assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid_o;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
      end else begin
         s_axi_awready_o <= !aw_held_ff && !(s_axi_awvalid_i && s_axi_awready_o) && !s_axi_bvalid_o;
         s_axi_wready_o <= !w_held_ff && !(s_axi_wvalid_i && s_axi_wready_o) && !s_axi_bvalid_o;
      end
   end

   // Port registers; only byte lane 0 carries the 8-bit value
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         port_a_ff <= '{data: pio_pkg::DATA_RESET, dir: pio_pkg::DIR_RESET, mode: pio_pkg::MODE_RESET};
         port_b_ff <= '{data: pio_pkg::DATA_RESET, dir: pio_pkg::DIR_RESET, mode: pio_pkg::MODE_RESET};
      end else if (do_write && wstrb0_ff && !aw_bad_ff) begin
         case (awaddr_ff)
            pio_pkg::PORT_A_DATA_OFS: port_a_ff.data <= wbyte_ff;
            pio_pkg::PORT_B_DATA_OFS: port_b_ff.data <= wbyte_ff;
            pio_pkg::PORT_A_CONTROL_OFS: begin
               // Mode word has low nibble all ones; modes 0, 1, 3 use all eight lines
               if (wbyte_ff[3:0] == pio_pkg::MODE_WORD_LOW) begin
                  if (wbyte_ff[7:6] != 2'h2) begin
                     port_a_ff.mode <= wbyte_ff[pio_pkg::MODE_POS +: 2];
                  end
               end else if (port_a_ff.mode == pio_pkg::MODE_BIT_IO) begin
                  port_a_ff.dir <= wbyte_ff;
               end
            end
            pio_pkg::PORT_B_CONTROL_OFS: begin
               // Port B ignores every mode word, bit mode included
               if (wbyte_ff[3:0] != pio_pkg::MODE_WORD_LOW) begin
                  port_b_ff.dir <= wbyte_ff;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= pio_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= aw_bad_ff ? pio_pkg::RESP_SLVERR : pio_pkg::RESP_OKAY;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   assign rd_addr = s_axi_araddr_i[3:0];

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_rerr = 1'b0;
      // Same refusal rule as the write side
      if ((s_axi_araddr_i[31:4] != 28'h0000000) || (s_axi_araddr_i[1:0] != 2'h0)) begin
         nxt_rerr = 1'b1;
      end else begin
         case (rd_addr)
            pio_pkg::PORT_A_DATA_OFS: nxt_rdata = {24'h000000, port_a_ff.data};
            pio_pkg::PORT_B_DATA_OFS: nxt_rdata = {24'h000000, port_b_ff.data};
            // Write-only: shadow copies in software stand in for readback
            pio_pkg::PORT_A_CONTROL_OFS: nxt_rdata = 32'h0000_0000;
            pio_pkg::PORT_B_CONTROL_OFS: nxt_rdata = 32'h0000_0000;
            default: nxt_rerr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= pio_pkg::RESP_OKAY;
      end else begin
         s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= nxt_rdata;
            s_axi_rresp_o <= nxt_rerr ? pio_pkg::RESP_SLVERR : pio_pkg::RESP_OKAY;
         end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   // Pin drive; dedicated B lines 0 and 1 are plain bits of the same latch
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         port_a_out_o <= 8'h00;
         port_a_oe_n_o <= 8'hff;
         port_a_mode_o <= pio_pkg::MODE_RESET;
         port_b_out_o <= 8'h00;
         port_b_oe_n_o <= 8'hff;
      end else begin
         port_a_out_o <= port_a_ff.data;
         port_a_mode_o <= port_a_ff.mode;
         // Mode 0 all outputs, mode 1 all inputs, mode 3 per bit
         case (port_a_ff.mode)
            2'h0: port_a_oe_n_o <= 8'h00;
            2'h1: port_a_oe_n_o <= 8'hff;
            default: port_a_oe_n_o <= port_a_ff.dir;
         endcase
         port_b_out_o <= port_b_ff.data;
         port_b_oe_n_o <= port_b_ff.dir;
      end
   end

   // Pin levels are synchronised but not mapped; a data read returns the latch
   logic unused_pins;
   assign unused_pins = ^{a_sync2_ff, b_sync2_ff, s_axi_wdata_i[31:8],
                          s_axi_wstrb_i[3:1], port_b_ff.mode};
endmodule

// ===== parallel_bit_io_ports_checker.sv
`timescale 1ns/1ps
module parallel_bit_io_ports_checker (
   input wire logic sys_clk_i, reset_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_bvalid_o,
   input wire logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
   input wire logic [31:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_rdata_o,
   input wire logic [1:0] s_axi_bresp_o, port_a_mode_o,
   input wire logic [7:0] port_a_out_o, port_a_oe_n_o, port_b_out_o, port_b_oe_n_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic ar_go, aw_go;
   assign ar_go = s_axi_arvalid_i && s_axi_arready_o;
   assign aw_go = s_axi_awvalid_i && s_axi_awready_o;
   a_read_answer: assert property (ar_go |=> s_axi_rvalid_o)
      else $error("read answer missing");
   a_ctrl_write_only: assert property (ar_go && s_axi_araddr_i inside {32'h4, 32'hc} |=>
      s_axi_rdata_o == 32'h0) else $error("control read not zero");
   a_port_a_readback: assert property (ar_go && s_axi_araddr_i == 32'h0 |=>
      s_axi_rdata_o == {24'h0, port_a_out_o}) else $error("port A read wrong");
   a_port_b_readback: assert property (ar_go && s_axi_araddr_i == 32'h8 |=>
      s_axi_rdata_o == {24'h0, port_b_out_o}) else $error("port B read wrong");
   a_write_answer: assert property (aw_go |-> ##[1:4] s_axi_bvalid_o)
      else $error("write answer missing");
   a_unmapped_error: assert property (aw_go && (s_axi_awaddr_i > 32'hc || s_axi_awaddr_i[1:0] != 2'h0)
      |-> ##[1:4] (s_axi_bvalid_o && s_axi_bresp_o == 2'h2)) else $error("bad address not refused");
   a_mode0_drives: assert property (port_a_mode_o == 2'h0 && $stable(port_a_mode_o)
      |-> port_a_oe_n_o == 8'h00) else $error("mode 0 not driving");
   a_mode1_floats: assert property (port_a_mode_o == 2'h1 && $stable(port_a_mode_o)
      |-> port_a_oe_n_o == 8'hff) else $error("mode 1 not floating");
   a_latch_holds: assert property ($changed(port_b_oe_n_o) |-> $stable(port_b_out_o))
      else $error("latch moved on direction change");
   c_mode0: cover property (port_a_mode_o == 2'h0);
   c_refused: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
   c_b_driven: cover property (port_b_oe_n_o == 8'h00);
endmodule
bind parallel_bit_io_ports parallel_bit_io_ports_checker chk_u (.*);

// ===== pio_line_model.sv
`timescale 1ns/1ps
module pio_line_model (
   input wire logic [7:0] out_i, // Block drive value
   input wire logic [7:0] oe_n_i, // Low drives
   input wire logic [7:0] ext_i, // Outside source level
   output logic [7:0] pin_o // Resolved line levels
);
   // No timekeeper fitted, so lines 2 and 3 behave as plain lines
   assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// ===== test_parallel_bit_io_ports.sv
`timescale 1ns/1ps
module test_parallel_bit_io_ports;
   logic sys_clk_i = 0, reset_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_arready_o, s_axi_rvalid_o;
   logic [31:0] s_axi_awaddr_i = 0, s_axi_wdata_i = 0, s_axi_araddr_i = 0, s_axi_rdata_o, rd;
   logic [3:0] s_axi_wstrb_i = 4'hf;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, port_a_mode_o, rsp;
   logic [7:0] port_a_in_i, port_a_out_o, port_a_oe_n_o, port_b_in_i, port_b_out_o, port_b_oe_n_o;
   int n_errors = 0, checks = 0;
   // Software copies of the write-only control registers
   logic [7:0] a_ctrl_copy = 8'hff, b_ctrl_copy = 8'hff, saved_copy;
   always #2.5 sys_clk_i = ~sys_clk_i;
   parallel_bit_io_ports dut_u (.*);
   pio_line_model line_a_u (.out_i(port_a_out_o), .oe_n_i(port_a_oe_n_o), .ext_i(8'h3c), .pin_o(port_a_in_i));
   pio_line_model line_b_u (.out_i(port_b_out_o), .oe_n_i(port_b_oe_n_o), .ext_i(8'hc3), .pin_o(port_b_in_i));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic aw, w;
      aw = 0;
      w = 0;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1;
      s_axi_wvalid_i <= 1;
      s_axi_bready_i <= 1;
      while (!(aw && w)) begin
         @(posedge sys_clk_i);
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw = 1;
            s_axi_awvalid_i <= 0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w = 1;
            s_axi_wvalid_i <= 0;
         end
      end
      do @(posedge sys_clk_i); while (!s_axi_bvalid_o);
      rsp = s_axi_bresp_o;
      s_axi_bready_i <= 0;
      // Pins follow the register one cycle later
      repeat (2) @(posedge sys_clk_i);
   endtask
   task automatic rdr(input logic [31:0] a);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1;
      s_axi_rready_i <= 1;
      do @(posedge sys_clk_i); while (!s_axi_arready_o);
      s_axi_arvalid_i <= 0;
      do @(posedge sys_clk_i); while (!s_axi_rvalid_o);
      rd = s_axi_rdata_o;
      rsp = s_axi_rresp_o;
      s_axi_rready_i <= 0;
      @(posedge sys_clk_i);
   endtask
   task end_of_test;
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      end_of_test;
   end
   initial begin
      repeat (20) @(posedge sys_clk_i);
      reset_n_i <= 1;
      chk("a_oe_reset", port_a_oe_n_o, 8'hff);
      chk("a_mode_reset", port_a_mode_o, pio_pkg::MODE_RESET);
      chk("b_oe_reset", port_b_oe_n_o, 8'hff);
      repeat (2) @(posedge sys_clk_i);
      // Start-up code: bit mode on both ports; all inputs is already the reset direction
      wr(32'h4, 32'hcf);
      chk("a_startup_mode", port_a_mode_o, pio_pkg::MODE_BIT_IO);
      wr(32'hc, 32'hcf);
      chk("b_startup_oe", port_b_oe_n_o, b_ctrl_copy);
      wr(32'h0, 32'ha5);
      chk("wr_okay", rsp, pio_pkg::RESP_OKAY);
      chk("a_still_input", port_a_oe_n_o, 8'hff);
      chk("a_latch", port_a_out_o, 8'ha5);
      rdr(32'h4);
      chk("a_ctrl_read", rd, 32'h0);
      a_ctrl_copy = 8'h30;
      wr(32'h4, {24'h0, a_ctrl_copy});
      chk("a_dir", port_a_oe_n_o, 8'h30);
      chk("a_pins", port_a_in_i, 8'hb5);
      rdr(32'h0);
      chk("a_data_read", rd, 32'ha5);
      wr(32'h8, 32'h5a);
      b_ctrl_copy = 8'h00;
      wr(32'hc, {24'h0, b_ctrl_copy});
      chk("b_dir", port_b_oe_n_o, 8'h00);
      chk("b_out", port_b_in_i, 8'h5a);
      rdr(32'hc);
      chk("b_ctrl_read", rd, 32'h0);
      rdr(32'h8);
      wr(32'h8, rd & ~32'h3);
      chk("b_rmw", port_b_out_o, 8'h58);
      wr(32'hc, 32'h0f);
      chk("b_mode_ignored", port_b_oe_n_o, 8'h00);
      // Temporary reconfiguration: save the copy, change, restore from the copy
      saved_copy = b_ctrl_copy;
      b_ctrl_copy = 8'hf0;
      wr(32'hc, {24'h0, b_ctrl_copy});
      chk("b_temp_dir", port_b_oe_n_o, 8'hf0);
      b_ctrl_copy = saved_copy;
      wr(32'hc, {24'h0, b_ctrl_copy});
      chk("b_restored", port_b_oe_n_o, 8'h00);
      chk("b_latch_kept", port_b_out_o, 8'h58);
      for (int m = 0; m < 4; m++) begin
         wr(32'h4, {24'h0, m[1:0], 6'h0f});
         chk("a_mode", port_a_mode_o, (m == 2) ? 2'h1 : m[1:0]);
         if (m < 3)
            chk("a_mode_oe", port_a_oe_n_o, (m == 0) ? 8'h00 : 8'hff);
      end
      chk("a_dir_kept", port_a_oe_n_o, a_ctrl_copy);
      wr(32'h10, 32'h0);
      chk("bad_wr", rsp, pio_pkg::RESP_SLVERR);
      wr(32'h5, 32'h0);
      chk("unaligned_wr", rsp, pio_pkg::RESP_SLVERR);
      rdr(32'h0);
      chk("bad_wr_no_effect", rd, 32'ha5);
      rdr(32'h6);
      chk("bad_rd", rsp, pio_pkg::RESP_SLVERR);
      end_of_test;
   end
endmodule
